// >>> logic/guard_pkg.sv
// Shared constants and types for the guard timer block.
// Assumes a single 25 MHz system clock and an 8-bit processor data space.
package guard_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int OSC_HZ = 128_000;
  localparam int TICK_DIV = CLK_HZ / OSC_HZ;

  localparam logic [7:0] CAUSE_OFS = 8'h54;
  localparam logic [7:0] CTRL_OFS = 8'h60;
  localparam logic [7:0] IO_BIAS = 8'h20;
  localparam logic [7:0] EXT_IO_BASE = 8'h60;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  localparam int SCAN_BIT = 4;
  localparam int GUARD_BIT = 3;
  localparam int UV_BIT = 2;
  localparam int PIN_BIT = 1;
  localparam int PU_BIT = 0;

  localparam int IRQF_BIT = 7;
  localparam int IRQE_BIT = 6;
  localparam int SEL3_BIT = 5;
  localparam int UNLOCK_BIT = 4;
  localparam int RME_BIT = 3;

  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam int BASE_TICKS = 2048;
  localparam logic [3:0] SEL_MAX = 4'h9;
  localparam int CNT_W = 21;

  typedef enum logic [1:0] {
    LOCK_IDLE = 2'b01,
    LOCK_OPEN = 2'b10
  } lock_state_t;

endpackage

// >>> logic/guard_osc_div.sv
// Divider that stands in for the separate watchdog oscillator.
// Assumes the system clock runs continuously, also in every sleep mode.
`timescale 1ns/1ps
module guard_osc_div import guard_pkg::*; #(
  parameter int DIV = TICK_DIV
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  output logic o_tick
);

  logic [15:0] count;

  // One enable pulse per oscillator period; never gated by sleep.
  always_ff @(posedge i_clk) begin // see (R06)
    if (!i_nrst) begin
      count <= 16'h0000;
      o_tick <= 1'b0;
    end else if (count == 16'(DIV - 1)) begin
      count <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      o_tick <= 1'b0;
    end
  end

endmodule

// >>> logic/guard_timeout_cnt.sv
// Oscillator-tick counter with a selectable time-out.
// Assumes i_tick is a one-cycle enable and i_restart a one-cycle pulse.
`timescale 1ns/1ps
module guard_timeout_cnt import guard_pkg::*; #(
  parameter int BASE = BASE_TICKS
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic i_restart,
  input wire logic i_run,
  input wire logic [3:0] i_sel,
  output logic o_timeout
);

  logic [CNT_W-1:0] count;
  logic [3:0] sel_eff;
  logic [CNT_W-1:0] limit;

  // Reserved codes fall back to the longest period.
  assign sel_eff = (i_sel > SEL_MAX) ? SEL_MAX : i_sel; // see (R24)
  assign limit = CNT_W'(BASE) << sel_eff; // see (R10)

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      count <= '0;
      o_timeout <= 1'b0;
    end else if (i_restart || !i_run) begin // see (R02)
      count <= '0;
      o_timeout <= 1'b0;
    end else if (i_tick && count >= limit - CNT_W'(1)) begin // see (R01)
      count <= '0;
      o_timeout <= 1'b1;
    end else begin
      count <= i_tick ? count + CNT_W'(1) : count;
      o_timeout <= 1'b0;
    end
  end

  restart_clear_a: assert property ( // see (R02)
    @(posedge i_clk) disable iff (!i_nrst)
    i_restart |=> (count == '0) && !o_timeout)
    else $error("counter not cleared by restart");

endmodule

// >>> logic/guard_timer_top.sv
// Guard timer with reset-cause flags, reached over the processor data space.
// Assumes the core drives one access per cycle and the reset controller
// reports each reset source as a level synchronous to I_REF_CLK.
//
// Contract
// (R01) Count oscillator cycles; at the selected time-out give interrupt or reset.
// (R02) Software restarts in time; a restart clears the count to zero.
// (R03) Interrupt mode raises a request on time-out that can wake the core.
// (R04) Reset mode asserts a system reset on time-out, not an interrupt.
// (R05) Combined mode: first time-out interrupts, a later one resets.
// (R06) Once enabled, counter and oscillator run in every sleep mode.
// (R07) Always-on fuse forces reset mode; enables read 1 and 0, unwritable.
// (R08) Unlock write sets change_unlock and reset_mode_enable together.
// (R09) Within four cycles one write sets new mode and period; else refused.
// (R10) Time-out period selectable from 16 ms to 8 s.
// (R11) Software restarts the counter before shortening the period.
// (R12) After a watchdog reset the watchdog stays enabled.
// (R13) Startup software clears guard_reset_flag, then reset_mode_enable.
// (R14) scan_reset_flag set by scan reset; cleared by power-up or zero write.
// (R15) guard_reset_flag set by watchdog reset; cleared by power-up or zero.
// (R16) undervolt_reset_flag set by brown-out; cleared by power-up or zero.
// (R17) pin_reset_flag set by pin reset; cleared by power-up or zero write.
// (R18) powerup_reset_flag set on power-up; cleared only by a zero write.
// (R19) timeout_irq_flag set on interrupt time-out; cleared by vector or one.
// (R20) Interrupt delivered only with global enable, irq enable and flag set.
// (R21) Cause register at data offset 0x54, short I/O address 0x34.
// (R22) Hardware clears change_unlock four cycles after it was set.
// (R23) While guard_reset_flag is set, reset_mode_enable is forced to one.
// (R24) Code 0 gives 2048 cycles, doubling up to code 9; 10-15 reserved.
// (R25) Combined mode: the vector clears irq enable and flag in hardware.
// (R26) Events between restart, configuration and time-out are never lost.
`timescale 1ns/1ps
module guard_timer_top import guard_pkg::*; #(
  parameter int TICK_CYCLES = TICK_DIV,
  parameter int BASE_COUNT = BASE_TICKS
) (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic [7:0] I_ADDR,
  input wire logic I_IO_SPACE,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] I_WDATA,
  input wire logic I_RESTART,
  input wire logic I_IRQ_ACK,
  input wire logic I_GLOBAL_IRQ_EN,
  input wire logic I_ALWAYS_ON_FUSE,
  input wire logic I_POWERUP_RST,
  input wire logic I_PIN_RST,
  input wire logic I_UNDERVOLT_RST,
  input wire logic I_SCAN_RST,
  output logic [7:0] O_RDATA,
  output logic O_IRQ,
  output logic O_SYS_RST
);

  // Short I/O form reaches only registers below the extended I/O space.
  function automatic logic hits(input logic [7:0] addr, input logic io,
                                input logic [7:0] ofs);
    if (io) begin
      hits = (ofs < EXT_IO_BASE) && (addr == 8'(ofs - IO_BIAS));
    end else begin
      hits = (addr == ofs);
    end
  endfunction

  logic tick;
  logic timeout;
  logic [4:0] cause;
  logic irq_flag;
  logic irq_en;
  logic rst_en;
  logic [3:0] sel;
  lock_state_t lock_state;
  logic [2:0] unlock_cnt;
  logic unlock_open;
  logic wr_cause;
  logic wr_ctrl;
  logic rd_cause;
  logic rd_ctrl;
  logic rst_eff;
  logic irq_eff;
  logic do_irq;
  logic do_rst;
  logic unlock_req;
  logic [7:0] ctrl_view;

  guard_osc_div #(
    .DIV(TICK_CYCLES)
  ) u_div (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .o_tick(tick)
  );

  // Everything runs on I_REF_CLK, so restarts and writes meet the
  // counter in the same domain and no event can be dropped.
  guard_timeout_cnt #(
    .BASE(BASE_COUNT)
  ) u_cnt (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_tick(tick),
    .i_restart(I_RESTART), // see (R26)
    .i_run(rst_eff || irq_eff),
    .i_sel(sel),
    .o_timeout(timeout)
  );

  assign wr_cause = I_WR && hits(I_ADDR, I_IO_SPACE, CAUSE_OFS); // see (R21)
  assign rd_cause = I_RD && hits(I_ADDR, I_IO_SPACE, CAUSE_OFS); // see (R21)
  assign wr_ctrl = I_WR && hits(I_ADDR, I_IO_SPACE, CTRL_OFS);
  assign rd_ctrl = I_RD && hits(I_ADDR, I_IO_SPACE, CTRL_OFS);

  assign unlock_open = (lock_state == LOCK_OPEN);
  assign unlock_req = wr_ctrl && I_WDATA[UNLOCK_BIT] && I_WDATA[RME_BIT];

  // Fuse and a pending watchdog reset flag both pin the reset enable.
  assign rst_eff = I_ALWAYS_ON_FUSE || cause[GUARD_BIT] || rst_en; // see (R07) (R12) (R23)
  assign irq_eff = !I_ALWAYS_ON_FUSE && irq_en; // see (R07)

  // In combined mode an unserviced flag turns the next time-out into a reset.
  assign do_irq = timeout && irq_eff && !(rst_eff && irq_flag); // see (R03) (R05)
  assign do_rst = timeout && rst_eff && !do_irq; // see (R04) (R05)

  assign ctrl_view = {irq_flag, irq_eff, sel[3], unlock_open, rst_eff,
                      sel[2:0]};

  // Unlock window: open for four cycles after the unlock write, or until a control write closes it; a repeated unlock write restarts the four cycles.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      lock_state <= LOCK_IDLE;
      unlock_cnt <= 3'h0;
    end else begin
      case (lock_state)
        LOCK_IDLE: begin
          if (unlock_req) begin // see (R08)
            lock_state <= LOCK_OPEN;
            unlock_cnt <= UNLOCK_CYCLES;
          end
        end
        LOCK_OPEN: begin
          if (unlock_req) begin
            unlock_cnt <= UNLOCK_CYCLES;
          end else if (wr_ctrl || unlock_cnt == 3'h1) begin // see (R22)
            lock_state <= LOCK_IDLE;
            unlock_cnt <= 3'h0;
          end else begin
            unlock_cnt <= unlock_cnt - 3'h1;
          end
        end
        default: begin
          lock_state <= LOCK_IDLE;
          unlock_cnt <= 3'h0;
        end
      endcase
    end
  end

  // Mode and period: clearing the reset enable or changing the period is
  // accepted only inside the open window; setting the enable always is.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      rst_en <= CTRL_RST[RME_BIT];
      irq_en <= CTRL_RST[IRQE_BIT];
      sel <= {CTRL_RST[SEL3_BIT], CTRL_RST[2:0]};
    end else begin
      if (wr_ctrl) begin
        irq_en <= I_WDATA[IRQE_BIT];
        if (unlock_open && !I_WDATA[UNLOCK_BIT]) begin // see (R09)
          rst_en <= I_WDATA[RME_BIT];
          sel <= {I_WDATA[SEL3_BIT], I_WDATA[2:0]}; // see (R10)
        end else begin
          rst_en <= rst_en || I_WDATA[RME_BIT]; // see (R09)
        end
      end else if (I_IRQ_ACK && rst_eff) begin
        irq_en <= 1'b0; // see (R25)
      end
      // The flag pins the enable, so clearing the flag alone never stops
      // the timer; a timed sequence is still needed after it.
      if (cause[GUARD_BIT]) begin
        rst_en <= 1'b1; // see (R12) (R23)
      end
    end
  end

  // Interrupt flag: a time-out set wins over a vector or write-one clear.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      irq_flag <= CTRL_RST[IRQF_BIT];
    end else if (do_irq) begin // see (R19)
      irq_flag <= 1'b1;
    end else if (I_IRQ_ACK || (wr_ctrl && I_WDATA[IRQF_BIT])) begin // see (R19) (R25)
      irq_flag <= 1'b0;
    end
  end

  // Request is level while all three conditions hold; sleep does not mask it.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_IRQ <= 1'b0;
      O_SYS_RST <= 1'b0;
    end else begin
      O_IRQ <= irq_flag && irq_eff && I_GLOBAL_IRQ_EN; // see (R20) (R03)
      O_SYS_RST <= do_rst; // see (R04)
    end
  end

  // Cause flags survive every reset but power-up; I_NRST leaves them alone.
  // A zero write clears a flag, a one write leaves it, and a source that
  // is active in the same cycle wins.
  always_ff @(posedge I_REF_CLK) begin
    if (I_POWERUP_RST) begin
      cause <= 5'(CAUSE_RST) | (5'h01 << PU_BIT); // see (R18) (R14) (R15)
    end else begin
      cause[PU_BIT] <= cause[PU_BIT] && !(wr_cause && !I_WDATA[PU_BIT]); // see (R18)
      cause[PIN_BIT] <= I_PIN_RST ||
        (cause[PIN_BIT] && !(wr_cause && !I_WDATA[PIN_BIT])); // see (R17)
      cause[UV_BIT] <= I_UNDERVOLT_RST ||
        (cause[UV_BIT] && !(wr_cause && !I_WDATA[UV_BIT])); // see (R16)
      cause[GUARD_BIT] <= do_rst ||
        (cause[GUARD_BIT] && !(wr_cause && !I_WDATA[GUARD_BIT])); // see (R15)
      cause[SCAN_BIT] <= I_SCAN_RST ||
        (cause[SCAN_BIT] && !(wr_cause && !I_WDATA[SCAN_BIT])); // see (R14)
    end
  end

  // Read data is captured on the read and stands until the next read.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_RDATA <= UNMAPPED_READ;
    end else if (rd_cause) begin
      O_RDATA <= {3'h0, cause}; // see (R21)
    end else if (rd_ctrl) begin
      O_RDATA <= ctrl_view; // see (R07) (R23)
    end else if (I_RD) begin
      O_RDATA <= UNMAPPED_READ;
    end
  end

  unlock_close_a: assert property ( // see (R22)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (unlock_open && unlock_cnt == 3'h1 && !I_WR) |=> !unlock_open)
    else $error("unlock window stayed open too long");

  unlock_span_a: assert property ( // see (R09)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (unlock_req && !unlock_open) ##1 (!I_WR)[*3] |=> unlock_open)
    else $error("unlock window closed early");

  clear_refused_a: assert property ( // see (R09)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (wr_ctrl && !unlock_open && rst_en) |=> rst_en)
    else $error("reset enable cleared without unlock");

  fuse_reset_a: assert property ( // see (R07)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (I_ALWAYS_ON_FUSE && timeout) |=> O_SYS_RST && !O_IRQ)
    else $error("fuse time-out did not reset");

  guard_flag_a: assert property ( // see (R15)
    @(posedge I_REF_CLK) disable iff (!I_NRST || I_POWERUP_RST)
    O_SYS_RST |-> cause[GUARD_BIT])
    else $error("watchdog reset did not set its flag");

  combined_first_a: assert property ( // see (R05)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (timeout && rst_eff && irq_eff && !irq_flag) |=> irq_flag && !O_SYS_RST)
    else $error("combined mode first time-out wrong");

  irq_gate_a: assert property ( // see (R20)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    ##1 O_IRQ == $past(irq_flag && irq_eff && I_GLOBAL_IRQ_EN))
    else $error("interrupt output does not follow its gate");

  vector_clear_a: assert property ( // see (R25)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (I_IRQ_ACK && rst_eff && !do_irq && !wr_ctrl) |=> !irq_flag && !irq_en)
    else $error("vector did not clear flag and enable");

  powerup_flag_a: assert property ( // see (R18)
    @(posedge I_REF_CLK)
    I_POWERUP_RST |=> cause == 5'h01)
    else $error("power-up flags wrong");

  reset_mode_a: assert property ( // see (R04)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (timeout && rst_eff && !irq_eff) |=> O_SYS_RST)
    else $error("reset mode time-out did not reset");

  irq_mode_a: assert property ( // see (R03)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (timeout && irq_eff && !rst_eff) |=> irq_flag && !O_SYS_RST)
    else $error("interrupt mode time-out wrong");

  guard_force_a: assert property ( // see (R23)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    cause[GUARD_BIT] |=> rst_en)
    else $error("reset enable not held by reset flag");

  period_keep_a: assert property ( // see (R09)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (wr_ctrl && !unlock_open) |=> $stable(sel))
    else $error("period changed without unlock");

  unlock_arm_a: assert property ( // see (R09)
    @(posedge I_REF_CLK) disable iff (!I_NRST)
    (unlock_req && !unlock_open) |=>
      unlock_open && unlock_cnt == UNLOCK_CYCLES)
    else $error("unlock window not armed");

endmodule

// >>> verification/core_model.sv
// Processor core stand-in that executes the time-out vector.
// Assumes it shares the system clock with the guard timer.
`timescale 1ns/1ps
module core_model (
  input wire logic i_clk,
  input wire logic i_irq,
  input wire logic i_serve,
  output logic o_ack
);
  logic [1:0] hold = 2'h0;
  initial o_ack = 1'b0;
  // A hold-off keeps one request from running the vector twice.
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (i_irq && i_serve) begin
      o_ack <= 1'b1;
      hold <= 2'h3;
    end
  end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the guard timer top level.
// Assumes the core stand-in of core_model.sv and shortened counts.
`timescale 1ns/1ps
module tb;
  localparam int TK = 4;
  localparam int BS = 4;
  localparam logic [7:0] FLAGB [3] = '{8'h02, 8'h04, 8'h10};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic io = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic restart = 1'b0;
  logic gie = 1'b0;
  logic fuse = 1'b0;
  logic pu = 1'b1;
  logic serve = 1'b0;
  logic [2:0] srcs = 3'h0;
  logic ack;
  logic [7:0] rdata;
  logic irq;
  logic srst;
  int error_cnt = 0;
  int checked = 0;
  int last = 0;
  int exp_c = 0;
  int hits = 0;

  always #20 clk = ~clk;

  guard_timer_top #(.TICK_CYCLES(TK), .BASE_COUNT(BS)) dut_u (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_IO_SPACE(io),
    .I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .I_RESTART(restart),
    .I_IRQ_ACK(ack), .I_GLOBAL_IRQ_EN(gie), .I_ALWAYS_ON_FUSE(fuse),
    .I_POWERUP_RST(pu), .I_PIN_RST(srcs[0]), .I_UNDERVOLT_RST(srcs[1]),
    .I_SCAN_RST(srcs[2]), .O_RDATA(rdata), .O_IRQ(irq), .O_SYS_RST(srst)
  );

  core_model core_u (.i_clk(clk), .i_irq(irq), .i_serve(serve),
    .o_ack(ack));

  task automatic complete_run();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic s);
    @(posedge clk);
    addr <= a;
    io <= s;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    io <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic s,
                        input logic [7:0] e);
    rd_reg(a, s);
    chk(rdata, e);
  endtask

  // Unlock write followed by the protected write two cycles later.
  task automatic set_cfg(input logic [7:0] d);
    wr_reg(8'h60, 8'h18);
    wr_reg(8'h60, d);
  endtask

  task automatic pulse_restart();
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask

  // Waits for the reset pulse (pick high) or the interrupt request.
  task automatic wait_hi(input logic pick, input int lim);
    int c;
    c = 0;
    #1;
    while ((pick ? srst : irq) !== 1'b1 && c < lim) begin
      @(posedge clk);
      #1;
      c++;
    end
    last = c;
    chk(8'(c < lim), 8'h01);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    pu <= 1'b0;
    rd_chk(8'h54, 1'b0, 8'h01);
    rd_chk(8'h34, 1'b1, 8'h01);
    rd_chk(8'h60, 1'b0, 8'h00);
    rd_chk(8'h55, 1'b0, 8'h00);
    wr_reg(8'h54, 8'hFF);
    rd_chk(8'h54, 1'b0, 8'h01);
    wr_reg(8'h54, 8'h00);
    rd_chk(8'h54, 1'b0, 8'h00);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) srcs <= 3'h1 << k;
      @(posedge clk) srcs <= 3'h0;
      rd_chk(8'h54, 1'b0, FLAGB[k]);
      wr_reg(8'h54, ~FLAGB[k]);
      rd_chk(8'h34, 1'b1, 8'h00);
    end
    for (int s = 0; s < 3; s++) begin
      pulse_restart();
      set_cfg(8'h08 | 8'(s));
      pulse_restart();
      wait_hi(1'b1, 400);
      exp_c = (TK * BS) << s;
      chk(8'(last > exp_c - 5 && last < exp_c + 5), 8'h01);
    end
    pulse_restart();
    rd_chk(8'h54, 1'b0, 8'h08);
    set_cfg(8'h02);
    rd_chk(8'h60, 1'b0, 8'h0A);
    wr_reg(8'h54, 8'h00);
    rd_chk(8'h54, 1'b0, 8'h00);
    rd_chk(8'h60, 1'b0, 8'h0A);
    pulse_restart();
    wr_reg(8'h60, 8'h18);
    repeat (5) @(posedge clk);
    wr_reg(8'h60, 8'h00);
    rd_chk(8'h60, 1'b0, 8'h0A);
    set_cfg(8'h00);
    rd_chk(8'h60, 1'b0, 8'h00);
    @(posedge clk) gie <= 1'b1;
    set_cfg(8'h42);
    pulse_restart();
    wait_hi(1'b0, 400);
    rd_chk(8'h60, 1'b0, 8'hC2);
    @(posedge clk) gie <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    wr_reg(8'h60, 8'hC2);
    rd_chk(8'h60, 1'b0, 8'h42);
    @(posedge clk) gie <= 1'b1;
    serve <= 1'b1;
    wait_hi(1'b0, 400);
    repeat (4) @(posedge clk);
    rd_chk(8'h60, 1'b0, 8'h42);
    wr_reg(8'h60, 8'h4A);
    wait_hi(1'b0, 400);
    repeat (4) @(posedge clk);
    rd_chk(8'h60, 1'b0, 8'h0A);
    wait_hi(1'b1, 400);
    rd_chk(8'h54, 1'b0, 8'h08);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(8'h54, 1'b0, 8'h08);
    rd_chk(8'h60, 1'b0, 8'h08);
    @(posedge clk) fuse <= 1'b1;
    wr_reg(8'h54, 8'h00);
    wr_reg(8'h60, 8'h40);
    rd_reg(8'h60, 1'b0);
    chk(rdata & 8'h48, 8'h08);
    pulse_restart();
    repeat (4) @(posedge clk);
    hits = 0;
    repeat (10) begin
      pulse_restart();
      repeat (8) begin
        @(posedge clk);
        #1;
        hits += int'(srst);
      end
    end
    chk(8'(hits), 8'h00);
    complete_run();
  end
endmodule
